// file: hw/system_clock_prescale_trim.sv
// Clock control top: APB registers, prescaler unlock, trim register, clock output and timer clock gate.
`timescale 1ns/100ps
module system_clock_prescale_trim
	import clock_ctrl_pkg::*;
#(
	parameter logic [23:0] FAST_CYCLES = 24'(FAST_DELAY_CYCLES),
	parameter logic [23:0] SLOW_CYCLES = 24'(SLOW_DELAY_CYCLES)
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fuse_set_t fuses,
	input wire logic [7:0] factory_trim,
	input wire logic crystal_input_pin,
	input wire logic timer_osc_input_pin,
	input wire logic wake_req,
	output logic ext_source_active,
	output logic [DOMAIN_COUNT-1:0] domain_clock_en,
	output logic core_reset,
	output logic clock_out_pin,
	output logic clock_out_oe,
	output logic timer_clock,
	output logic [7:0] rc_trim_value_o
);
	logic [3:0] code_reg;
	logic prescale_change_unlock_reg;
	logic [1:0] unlock_cnt_reg;
	logic [7:0] rc_trim_value_reg;
	logic timer_ext_clock_select_reg;
	logic init_pending_reg;
	logic [31:0] prdata_next;
	logic pslverr_next;
	logic setup_phase;
	logic write_taken;
	logic [7:0] wd;
	logic unlock_pattern;
	logic prescale_write;
	logic trim_write;
	logic timer_write;
	logic mapped;
	logic div_tick;
	logic div_level;
	logic hold;
	logic sut_reserved;

	// Divider shared by all clocked domains.
	glitch_free_divider divider (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.code_i(code_reg),
		.tick_reg(div_tick),
		.level_reg(div_level)
	);

	// Start-up and wake sequencer; its reset output is the chip reset seen by the core.
	clock_startup_timer #(
		.FAST_CYCLES(FAST_CYCLES),
		.SLOW_CYCLES(SLOW_CYCLES)
	) startup (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.startup_time_fuses(fuses.startup_time_fuses),
		.ext_selected(ext_source_active),
		.wake_req(wake_req),
		.core_reset_reg(core_reset),
		.hold_reg(hold),
		.sut_reserved_reg(sut_reserved)
	);

	// Bus decode; a write lands at the access edge, where pready is already high.
	always_comb begin
		setup_phase = psel && !penable;
		write_taken = psel && penable && pwrite && pready;
		wd = pwdata[7:0];
		unlock_pattern = wd[UNLOCK_BIT] && (wd[6:0] == 7'h00);
		prescale_write = write_taken && (paddr == PRESCALE_OFFSET);
		trim_write = write_taken && (paddr == TRIM_OFFSET);
		timer_write = write_taken && (paddr == TIMER_STATUS_OFFSET);
		mapped = (paddr == TRIM_OFFSET) || (paddr == PRESCALE_OFFSET) ||
			(paddr == TIMER_STATUS_OFFSET) || (paddr == STARTUP_STATUS_OFFSET);
	end

	// Read data is prepared in the setup cycle so every access needs no wait state.
	always_comb begin
		prdata_next = 32'h00000000;
		pslverr_next = 1'b0;
		case (paddr)
			TRIM_OFFSET: prdata_next[7:0] = rc_trim_value_reg;
			PRESCALE_OFFSET: begin
				prdata_next[UNLOCK_BIT] = prescale_change_unlock_reg;
				prdata_next[CODE_MSB:0] = code_reg;
			end
			TIMER_STATUS_OFFSET: prdata_next[EXT_CLOCK_SELECT_BIT] = timer_ext_clock_select_reg;
			STARTUP_STATUS_OFFSET: begin
				prdata_next[STATUS_EXT_SOURCE_BIT] = ext_source_active;
				prdata_next[STATUS_RUNNING_BIT] = !core_reset;
				prdata_next[STATUS_SUT_RESERVED_BIT] = sut_reserved;
			end
			default: pslverr_next = 1'b1;
		endcase
	end

	// APB answer registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= setup_phase;
			pslverr <= setup_phase && !mapped;
			if (setup_phase && !pwrite) begin
				prdata <= prdata_next;
			end else if (setup_phase) begin
				prdata <= 32'h00000000;
			end
		end
	end

	// The fuse straps are caught after reset release, since an async reset may load constants only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_pending_reg <= 1'b1;
		end else if (ce) begin
			init_pending_reg <= 1'b0;
		end
	end

	// Division code: loaded from the fuse once, later written only inside an open unlock window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_reg <= CODE_RESET_PLAIN;
		end else if (ce) begin
			if (init_pending_reg) begin
				code_reg <= fuses.divide_by_eight_fuse ? CODE_RESET_DIV8 : CODE_RESET_PLAIN;
			end else if (prescale_write && !wd[UNLOCK_BIT] && prescale_change_unlock_reg) begin
				code_reg <= wd[CODE_MSB:0];
			end
		end
	end

	// Unlock bit: set by the lone unlock pattern, cleared by the code write or after four cycles.
	// A second unlock write keeps the running count, so the window can never be stretched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale_change_unlock_reg <= 1'b0;
			unlock_cnt_reg <= 2'h0;
		end else if (ce) begin
			if (!prescale_change_unlock_reg) begin
				if (prescale_write && unlock_pattern && !init_pending_reg) begin
					prescale_change_unlock_reg <= 1'b1;
					unlock_cnt_reg <= 2'h0;
				end
			end else if (prescale_write && !wd[UNLOCK_BIT]) begin
				prescale_change_unlock_reg <= 1'b0;
			end else if (unlock_cnt_reg == 2'(UNLOCK_WINDOW_CYCLES - 1)) begin
				prescale_change_unlock_reg <= 1'b0;
			end else begin
				unlock_cnt_reg <= 2'(unlock_cnt_reg + 2'h1);
			end
		end
	end

	// Trim register; bit 7 is the range select and bits 6:0 the fine setting, passed raw to the oscillator.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_trim_value_reg <= TRIM_RESET;
			rc_trim_value_o <= TRIM_RESET;
		end else if (ce) begin
			if (init_pending_reg) begin
				rc_trim_value_reg <= factory_trim;
				rc_trim_value_o <= factory_trim;
			end else if (trim_write) begin
				rc_trim_value_reg <= wd;
				rc_trim_value_o <= wd;
			end
		end
	end

	// Timer clock select bit and the gated timer clock path.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_ext_clock_select_reg <= 1'b0;
			timer_clock <= 1'b0;
		end else if (ce) begin
			if (timer_write) begin
				timer_ext_clock_select_reg <= wd[EXT_CLOCK_SELECT_BIT];
			end
			timer_clock <= timer_ext_clock_select_reg && timer_osc_input_pin;
		end
	end

	// Source select and clock output; the output keeps running through the start-up delay.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_source_active <= 1'b0;
			clock_out_pin <= 1'b0;
			clock_out_oe <= 1'b0;
		end else if (ce) begin
			ext_source_active <= (fuses.clock_source_select_fuses == EXT_CLOCK_CODE);
			clock_out_oe <= fuses.clock_out_fuse;
			clock_out_pin <= fuses.clock_out_fuse && div_level;
		end
	end

	// One enable per clocked domain, all from the same divider tick and halted while held.
	generate
		for (genvar i = 0; i < DOMAIN_COUNT; i++) begin : domain_gate
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					domain_clock_en[i] <= 1'b0;
				end else if (ce) begin
					domain_clock_en[i] <= div_tick && !hold;
				end
			end
		end
	endgenerate

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	sequence unlock_opened_s;
		!prescale_change_unlock_reg && prescale_write && unlock_pattern && !init_pending_reg;
	endsequence
	sequence quiet_window_s;
		!prescale_write [*4];
	endsequence

	unlock_timeout_a: assert property (unlock_opened_s ##1 quiet_window_s |=> !prescale_change_unlock_reg)
		else $error("unlock bit not cleared four cycles after set");
	unlock_open_a: assert property (unlock_opened_s ##1 !prescale_write [*3] |-> prescale_change_unlock_reg)
		else $error("unlock bit dropped inside its window");
	unlock_pattern_a: assert property (prescale_write && wd[UNLOCK_BIT] && wd[6:0] != 7'h00 &&
		!prescale_change_unlock_reg |=> !prescale_change_unlock_reg)
		else $error("unlock set with other bits nonzero");
	code_locked_a: assert property (prescale_write && !prescale_change_unlock_reg && !init_pending_reg
		|=> code_reg == $past(code_reg))
		else $error("code changed without unlock");
	code_update_a: assert property (prescale_write && !wd[UNLOCK_BIT] && prescale_change_unlock_reg &&
		!init_pending_reg |=> code_reg == $past(wd[3:0]) && !prescale_change_unlock_reg)
		else $error("code write inside window not taken");
	reset_code_a: assert property (init_pending_reg |=>
		code_reg == ($past(fuses.divide_by_eight_fuse) ? CODE_RESET_DIV8 : CODE_RESET_PLAIN))
		else $error("reset division code wrong");
	reserved_read_a: assert property (setup_phase && !pwrite && paddr == PRESCALE_OFFSET
		|=> pready && prdata[6:4] == 3'h0 && prdata[31:8] == 24'h000000)
		else $error("prescale reserved bits not zero");
	timer_gate_a: assert property (!timer_ext_clock_select_reg |=> !timer_clock)
		else $error("timer clock passed while external select is off");
	// Checks start only once the fuse straps have been caught, so the reset values of the outputs do not trip them.
	clock_out_a: assert property (!init_pending_reg |=> clock_out_oe == $past(fuses.clock_out_fuse) &&
		(clock_out_pin == ($past(fuses.clock_out_fuse) && $past(div_level))))
		else $error("clock output not the divided clock");
	domain_same_a: assert property (!init_pending_reg |=>
		domain_clock_en == {DOMAIN_COUNT{$past(div_tick) && !$past(hold)}})
		else $error("domain enables disagree");
	ext_select_a: assert property (!init_pending_reg |=> ext_source_active ==
		($past(fuses.clock_source_select_fuses) == EXT_CLOCK_CODE))
		else $error("external source flag wrong");
endmodule

// file: hw/clock_ctrl_pkg.sv
// Package with register map, field positions, reset values, timing and types of the clock control block.
package clock_ctrl_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] TRIM_OFFSET = 8'h00;
	localparam logic [7:0] PRESCALE_OFFSET = 8'h04;
	localparam logic [7:0] TIMER_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] STARTUP_STATUS_OFFSET = 8'h0C;
	// Field positions.
	localparam int UNLOCK_BIT = 7;
	localparam int CODE_MSB = 3;
	localparam int TRIM_RANGE_BIT = 7;
	localparam int EXT_CLOCK_SELECT_BIT = 0;
	localparam int STATUS_EXT_SOURCE_BIT = 0;
	localparam int STATUS_RUNNING_BIT = 1;
	localparam int STATUS_SUT_RESERVED_BIT = 2;
	// Reset and load values.
	localparam logic [3:0] CODE_RESET_PLAIN = 4'h0;
	localparam logic [3:0] CODE_RESET_DIV8 = 4'h3;
	localparam logic [3:0] CODE_MAX = 4'h8;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam logic [3:0] EXT_CLOCK_CODE = 4'h0;
	localparam logic [1:0] SUT_NO_EXTRA = 2'h0;
	localparam logic [1:0] SUT_FAST = 2'h1;
	localparam logic [1:0] SUT_SLOW = 2'h2;
	// Timing figures and their cycle counts at the bus clock rate.
	localparam int CLK_PERIOD_NS = 8;
	localparam int UNLOCK_WINDOW_CYCLES = 4;
	localparam int WAKE_CYCLES = 6;
	localparam int RESET_BASE_CYCLES = 14;
	localparam int FAST_DELAY_MS = 4;
	localparam int SLOW_DELAY_MS = 64;
	localparam int FAST_DELAY_CYCLES = (FAST_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_DELAY_CYCLES = (SLOW_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOMAIN_COUNT = 4;

	// Fuse bits, a one meaning programmed.
	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_fuses;
		logic clock_out_fuse;
		logic divide_by_eight_fuse;
	} fuse_set_t;

	// Start-up sequencer states.
	typedef enum logic [2:0] {
		ST_BASE_DELAY,
		ST_EXTRA_DELAY,
		ST_HELD,
		ST_RUN,
		ST_WAKE
	} startup_state_t;
endpackage

// file: hw/glitch_free_divider.sv
// Divider that makes the system clock tick and level and changes factor only at a period boundary.
`timescale 1ns/100ps
module glitch_free_divider
	import clock_ctrl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [3:0] code_i,
	output logic tick_reg,
	output logic level_reg
);
	logic [3:0] active_reg;
	logic [7:0] cnt_reg;
	logic [3:0] eff_code;
	logic [7:0] mask;
	logic [7:0] cnt_next;
	logic [3:0] active_next;
	logic [7:0] mask_next;
	logic at_end;

	// Reserved codes fall back to the slowest factor, which can never overclock the core.
	always_comb begin
		eff_code = (code_i > CODE_MAX) ? CODE_MAX : code_i;
		mask = 8'((16'h0001 << active_reg) - 16'h0001);
		at_end = (cnt_reg == mask);
		cnt_next = at_end ? 8'h00 : 8'(cnt_reg + 8'h01);
		active_next = at_end ? eff_code : active_reg;
		mask_next = 8'((16'h0001 << active_next) - 16'h0001);
	end

	// The new factor is taken only when the old period ends, so no short pulse is ever made.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= 4'h0;
			cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
			level_reg <= 1'b0;
		end else if (ce) begin
			active_reg <= active_next;
			cnt_reg <= cnt_next;
			tick_reg <= at_end;
			level_reg <= (active_next == 4'h0) || (cnt_next <= (mask_next >> 1));
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	// One whole old period passes before the new factor governs the counter.
	tick_period_a: assert property (at_end |=> cnt_reg == 8'h00 && active_reg == $past(eff_code))
		else $error("divider did not restart with the new factor at the period end");
	hold_factor_a: assert property (!at_end |=> active_reg == $past(active_reg))
		else $error("divider factor changed inside a period");
endmodule

// file: hw/clock_startup_timer.sv
// Start-up and wake delay sequencer that holds the clocked domains until the source is stable.
`timescale 1ns/100ps
module clock_startup_timer
	import clock_ctrl_pkg::*;
#(
	parameter logic [23:0] FAST_CYCLES = 24'(FAST_DELAY_CYCLES),
	parameter logic [23:0] SLOW_CYCLES = 24'(SLOW_DELAY_CYCLES)
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [1:0] startup_time_fuses,
	input wire logic ext_selected,
	input wire logic wake_req,
	output logic core_reset_reg,
	output logic hold_reg,
	output logic sut_reserved_reg
);
	startup_state_t state_reg;
	logic [23:0] cnt_reg;
	logic [23:0] extra;

	// Other clock sources are outside this block, so they only get the base delay.
	always_comb begin
		case (startup_time_fuses)
			SUT_FAST: extra = ext_selected ? FAST_CYCLES : 24'h000000;
			SUT_SLOW: extra = ext_selected ? SLOW_CYCLES : 24'h000000;
			default: extra = 24'h000000;
		endcase
	end

	// A reserved start-up code with the external source selected keeps the core in reset rather than guessing a delay.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_BASE_DELAY;
			cnt_reg <= 24'h000000;
			core_reset_reg <= 1'b1;
			hold_reg <= 1'b1;
			sut_reserved_reg <= 1'b0;
		end else if (ce) begin
			sut_reserved_reg <= ext_selected && (startup_time_fuses == 2'h3);
			case (state_reg)
				ST_BASE_DELAY: begin
					cnt_reg <= 24'(cnt_reg + 24'h000001);
					if (cnt_reg == 24'(RESET_BASE_CYCLES - 1)) begin
						cnt_reg <= 24'h000000;
						if (ext_selected && startup_time_fuses == 2'h3) begin
							state_reg <= ST_HELD;
						end else if (extra == 24'h000000) begin
							state_reg <= ST_RUN;
							core_reset_reg <= 1'b0;
							hold_reg <= 1'b0;
						end else begin
							state_reg <= ST_EXTRA_DELAY;
						end
					end
				end
				ST_EXTRA_DELAY: begin
					cnt_reg <= 24'(cnt_reg + 24'h000001);
					if (cnt_reg == 24'(extra - 24'h000001)) begin
						state_reg <= ST_RUN;
						core_reset_reg <= 1'b0;
						hold_reg <= 1'b0;
					end
				end
				ST_RUN: begin
					if (wake_req) begin
						state_reg <= ST_WAKE;
						cnt_reg <= 24'h000000;
						hold_reg <= 1'b1;
					end
				end
				ST_WAKE: begin
					cnt_reg <= 24'(cnt_reg + 24'h000001);
					if (cnt_reg == 24'(WAKE_CYCLES - 1)) begin
						state_reg <= ST_RUN;
						hold_reg <= 1'b0;
					end
				end
				ST_HELD: state_reg <= ST_HELD;
				default: state_reg <= ST_BASE_DELAY;
			endcase
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	sequence wake_start_s;
		state_reg == ST_RUN && wake_req;
	endsequence
	// A wake from power-down holds the domains for exactly six cycles.
	wake_length_a: assert property (wake_start_s |=> hold_reg [*6] ##1 !hold_reg)
		else $error("wake hold did not last six cycles");
endmodule

// file: sim/clock_source_model.sv
// Far-side model: steady external clocks and a watcher of the divided domain enables.
`timescale 1ns/100ps
module clock_source_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] domain_clock_en,
	output logic crystal_input_pin,
	output logic timer_osc_input_pin,
	output int gap,
	output logic domains_agree
);
	int cnt;
	logic [1:0] phase;

	// The source pin follows the bus clock, so its rate never steps from one cycle to the next.
	assign crystal_input_pin = pclk;

	// Timer oscillator toggles every third cycle, a steady rate well below the bus clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
			timer_osc_input_pin <= 1'b0;
		end else begin
			phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
			if (phase == 2'h2) begin
				timer_osc_input_pin <= ~timer_osc_input_pin;
			end
		end
	end

	// Measures the spacing of enable pulses and notes any disagreement between domains.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			gap <= 0;
			domains_agree <= 1'b1;
		end else begin
			if (domain_clock_en != {4{domain_clock_en[0]}}) begin
				domains_agree <= 1'b0;
			end
			if (domain_clock_en[0]) begin
				gap <= cnt + 1;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// file: sim/system_clock_prescale_trim_test.sv
// Self-checking bench for the clock control block: registers, unlock window, divider and clock outputs.
`timescale 1ns/100ps
module system_clock_prescale_trim_test;
	import clock_ctrl_pkg::*;
	localparam fuse_set_t FUSE_SET = '{clock_source_select_fuses: EXT_CLOCK_CODE,
		startup_time_fuses: SUT_NO_EXTRA, clock_out_fuse: 1'b1, divide_by_eight_fuse: 1'b1};
	localparam logic [7:0] FACTORY_TRIM = 8'h5A;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic wake_req = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, core_reset, ext_source_active, clock_out_pin, clock_out_oe, timer_clock;
	logic crystal_input_pin, timer_osc_input_pin, domains_agree, last_out, s;
	logic [3:0] domain_clock_en;
	logic [7:0] rc_trim_value_o;
	logic [7:0] trims [4];
	logic [32:0] exp_q[$];
	int gap;
	int err_count = 0;
	int check_count = 0;

	system_clock_prescale_trim #(.FAST_CYCLES(24'h14), .SLOW_CYCLES(24'h28)) system_clock_prescale_trim_inst (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fuses(FUSE_SET), .factory_trim(FACTORY_TRIM), .crystal_input_pin(crystal_input_pin),
		.timer_osc_input_pin(timer_osc_input_pin), .wake_req(wake_req), .ext_source_active(ext_source_active),
		.domain_clock_en(domain_clock_en), .core_reset(core_reset), .clock_out_pin(clock_out_pin),
		.clock_out_oe(clock_out_oe), .timer_clock(timer_clock), .rc_trim_value_o(rc_trim_value_o));

	clock_source_model clock_source_model_inst (.pclk(pclk), .presetn(presetn), .domain_clock_en(domain_clock_en),
		.crystal_input_pin(crystal_input_pin), .timer_osc_input_pin(timer_osc_input_pin), .gap(gap),
		.domains_agree(domains_agree));

	// Free-running bus clock, 8 ns period.
	always #4 pclk = ~pclk;

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// One APB transfer; it leaves the bus requested so a further transfer may follow at once.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) exp_q.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) check("pready", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		apb(1'b0, a, 32'h0, {err, e});
	endtask

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// The two writes go back to back with nothing in between, as software does with interrupts off.
	task automatic set_code(input logic [3:0] c);
		wr(PRESCALE_OFFSET, 32'h80);
		wr(PRESCALE_OFFSET, {28'h0, c});
		idle();
	endtask

	// Timer clock follows the oscillator input, gated by the select bit, one cycle late.
	task automatic timer_cycles(input logic sel);
		repeat (12) begin
			@(posedge pclk);
			s = timer_osc_input_pin;
			#1;
			check("timer clock", {31'h0, s & sel}, {31'h0, timer_clock});
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Each completed read answers the oldest noted expectation.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				check("read queue", 32'h1, 32'h0);
			end else begin
				check("prdata", exp_q[0][31:0], prdata);
				check("pslverr", {31'h0, exp_q[0][32]}, {31'h0, pslverr});
				void'(exp_q.pop_front());
			end
		end
	end

	// Cuts a hang short; the tests need well under this span.
	initial begin
		#(8 * 30000);
		err_count++;
		$display("[FAIL] run length expected end of tests seen timeout");
		finish_test();
	end

	initial begin
		int n;
		int t;
		void'($urandom(85580));
		trims = '{8'h7F, 8'h80, 8'h00, 8'($urandom)};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			#1;
		end while (core_reset !== 1'b0 && n < 100);
		check("start-up edges", 32'd14, 32'(n));
		check("ext source", 32'h1, {31'h0, ext_source_active});
		check("clock out enable", 32'h1, {31'h0, clock_out_oe});
		check("trim out", {24'h0, FACTORY_TRIM}, {24'h0, rc_trim_value_o});
		rd(PRESCALE_OFFSET, 32'h3, 1'b0);
		rd(TRIM_OFFSET, {24'h0, FACTORY_TRIM}, 1'b0);
		rd(STARTUP_STATUS_OFFSET, 32'h3, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		rd(TIMER_STATUS_OFFSET, 32'h0, 1'b0);
		idle();
		$display("Test reset values done");
		// No nonvolatile write runs in this bench, so any trim value is allowed here.
		for (int i = 0; i < 4; i++) begin
			wr(TRIM_OFFSET, {24'h0, trims[i]});
			rd(TRIM_OFFSET, {24'h0, trims[i]}, 1'b0);
			idle();
			check("trim out", {24'h0, trims[i]}, {24'h0, rc_trim_value_o});
		end
		$display("Test trim done");
		for (int c = 0; c <= 9; c++) begin
			set_code(4'(c));
			rd(PRESCALE_OFFSET, 32'(c), 1'b0);
			idle();
			repeat (600) @(posedge pclk);
			#1;
			check("period", (c > 8) ? 32'd256 : 32'd1 << c, 32'(gap));
			if (c >= 1 && c <= 6) begin
				t = 0;
				last_out = clock_out_pin;
				repeat (64) begin
					@(posedge pclk);
					#1;
					if (clock_out_pin !== last_out) t++;
					last_out = clock_out_pin;
				end
				check("clock out edges", 32'd128 >> c, 32'(t));
			end
		end
		$display("Test division codes done");
		wr(PRESCALE_OFFSET, 32'h80);
		wr(PRESCALE_OFFSET, 32'h80);
		wr(PRESCALE_OFFSET, 32'h02);
		rd(PRESCALE_OFFSET, 32'h2, 1'b0);
		wr(PRESCALE_OFFSET, 32'h80);
		wr(PRESCALE_OFFSET, 32'h80);
		idle();
		wr(PRESCALE_OFFSET, 32'h05);
		rd(PRESCALE_OFFSET, 32'h2, 1'b0);
		wr(PRESCALE_OFFSET, 32'h81);
		wr(PRESCALE_OFFSET, 32'h05);
		rd(PRESCALE_OFFSET, 32'h2, 1'b0);
		wr(PRESCALE_OFFSET, 32'h80);
		wr(PRESCALE_OFFSET, 32'h70);
		rd(PRESCALE_OFFSET, 32'h0, 1'b0);
		idle();
		$display("Test unlock window done");
		repeat (600) @(posedge pclk);
		wake_req <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge pclk);
			#1;
			if (domain_clock_en === 4'h0) n++;
		end
		check("wake hold", 32'd6, 32'(n));
		check("domains agree", 32'h1, {31'h0, domains_agree});
		$display("Test wake done");
		timer_cycles(1'b0);
		wr(TIMER_STATUS_OFFSET, 32'h1);
		rd(TIMER_STATUS_OFFSET, 32'h1, 1'b0);
		idle();
		timer_cycles(1'b1);
		$display("Test timer clock done");
		finish_test();
	end
endmodule
